// ### rtl/page_xlate_pkg.sv
// Constants and types shared by the page translation unit
package page_xlate_pkg;
  localparam int PAGE_OFFSET_BITS = 12;
  localparam int VADDR_BITS = 32;
  localparam int PADDR_BITS = 32;
  localparam int NUM_SOURCES = 7;
  localparam int MISS_CNT_BITS = 3;
  localparam int CACHE_ENTRIES = 8;
  localparam int VPN_BITS = VADDR_BITS - PAGE_OFFSET_BITS;
  localparam int PPN_BITS = PADDR_BITS - PAGE_OFFSET_BITS;
  localparam logic [MISS_CNT_BITS-1:0] MISS_CNT_RESET = 3'h0;
  localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    PH_NORMAL,
    PH_FETCH,
    PH_FILL
  } phase_type;
endpackage

// ### rtl/xlate_entry.sv
// One cached translation entry with its tag compare
`timescale 1ns/1ps
module xlate_entry #(
  parameter int VPN_W = 20,
  parameter int PPN_W = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Fill and invalidate
  input wire logic load,
  input wire logic flush,
  input wire logic [VPN_W-1:0] load_vpn,
  input wire logic [PPN_W-1:0] load_ppn,
  // Lookup ports, one per source
  input wire logic [6:0][VPN_W-1:0] look_vpn,
  output logic [6:0] look_hit,
  output logic [PPN_W-1:0] ppn,
  output logic [VPN_W-1:0] vpn,
  output logic valid
);
  always_ff @(posedge core_clk) begin
    if (!nrst || flush) begin
      valid <= 1'b0;
    end else if (load) begin
      valid <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      vpn <= '0;
      ppn <= '0;
    end else if (load) begin
      vpn <= load_vpn;
      ppn <= load_ppn;
    end
  end

  always_comb begin
    for (int s = 0; s < 7; s++) begin
      look_hit[s] = valid && (look_vpn[s] == vpn);
    end
  end
endmodule

// ### rtl/gpu_page_translation_unit.sv
// Page translation unit: per-source lookup, miss queue and table fetch
// Function
// - Translate virtual to physical at 4KB pages
// - Fetch entries from memory only on miss
// - On-chip cache keeps the eight most recently fetched entries
// - Compare each request against cached entries
// - Hit joins cached high bits with offset
// - Miss reads memory; access waits for refill
// - Accept seven sources, all may miss together
// - Three bit counter tracks outstanding misses
`timescale 1ns/1ps
module gpu_page_translation_unit #(
  parameter int NSRC = page_xlate_pkg::NUM_SOURCES,
  parameter int NENT = page_xlate_pkg::CACHE_ENTRIES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Requests from internal sources
  input wire logic [6:0] req_valid,
  input wire logic [6:0][31:0] req_vaddr,
  output logic [6:0] req_ready,
  // Translated accesses
  output logic [6:0] out_valid,
  output logic [6:0][31:0] out_paddr,
  input wire logic [6:0] out_ready,
  // Table base and invalidate
  input wire logic [31:0] table_base,
  input wire logic invalidate,
  // Page-table memory read port
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ready,
  input wire logic mem_rsp_valid,
  input wire logic [31:0] mem_rsp_data,
  // Status
  output logic [2:0] miss_count,
  output logic miss_phase
);
  localparam int OB = page_xlate_pkg::PAGE_OFFSET_BITS;
  localparam int VW = page_xlate_pkg::VPN_BITS;
  localparam int PW = page_xlate_pkg::PPN_BITS;
  localparam int IW = $clog2(NENT);

  page_xlate_pkg::phase_type phase_r;
  logic [NENT-1:0][6:0] ent_hit;
  logic [NENT-1:0][PW-1:0] ent_ppn;
  logic [NENT-1:0][VW-1:0] ent_vpn;
  logic [NENT-1:0] ent_valid;
  logic [6:0][VW-1:0] look_vpn;
  logic [6:0] hit;
  logic [6:0][PW-1:0] hit_ppn;
  logic [6:0] pend_r;
  logic [6:0] new_miss;
  logic [2:0] miss_cnt_r;
  logic [2:0] pend_pop;
  logic [2:0] new_cnt;
  logic [2:0] cur_src;
  logic [IW-1:0] victim_r;
  logic [NENT-1:0] load_vec;
  logic fill;
  logic [2:0] sel_r;
  logic found;
  logic [VW-1:0] fetch_vpn;

  always_comb begin
    for (int s = 0; s < 7; s++) begin
      look_vpn[s] = req_vaddr[s][31:OB];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NENT; g++) begin : g_ent
      xlate_entry #(.VPN_W(VW), .PPN_W(PW)) u_ent (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(load_vec[g]),
        .flush(invalidate),
        .load_vpn(fetch_vpn),
        .load_ppn(mem_rsp_data[31:OB]),
        .look_vpn(look_vpn),
        .look_hit(ent_hit[g]),
        .ppn(ent_ppn[g]),
        .vpn(ent_vpn[g]),
        .valid(ent_valid[g])
      );
    end
  endgenerate

  always_comb begin
    for (int s = 0; s < 7; s++) begin
      hit[s] = 1'b0;
      hit_ppn[s] = '0;
      for (int e = 0; e < NENT; e++) begin
        if (ent_hit[e][s]) begin
          hit[s] = 1'b1;
          hit_ppn[s] = hit_ppn[s] | ent_ppn[e];
        end
      end
    end
  end

  // A hitting source is taken when its output slot is free; a missing source stays pending
  always_comb begin
    for (int s = 0; s < 7; s++) begin
      req_ready[s] = !pend_r[s] && (!out_valid[s] || out_ready[s]) && hit[s];
      new_miss[s] = req_valid[s] && !pend_r[s] && !hit[s];
    end
  end

  // Translated output: high bits from entry, offset from request
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_valid <= '0;
      out_paddr <= '0;
    end else begin
      for (int s = 0; s < 7; s++) begin
        if (req_valid[s] && req_ready[s]) begin
          out_valid[s] <= 1'b1;
          out_paddr[s] <= {hit_ppn[s], req_vaddr[s][OB-1:0]};
        end else if (out_ready[s]) begin
          out_valid[s] <= 1'b0;
        end
      end
    end
  end

  // One pending flag per source: repeat misses of a source never add a count
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend_r <= '0;
    end else begin
      for (int s = 0; s < 7; s++) begin
        if (new_miss[s]) begin
          pend_r[s] <= 1'b1;
        end else if (fill && sel_r == 3'(s)) begin
          pend_r[s] <= 1'b0;
        end
      end
    end
  end

  // Pending population; one flag per source keeps it at seven or below
  always_comb begin
    pend_pop = '0;
    for (int s = 0; s < 7; s++) begin
      pend_pop = pend_pop + 3'(pend_r[s]);
    end
  end

  always_comb begin
    new_cnt = '0;
    for (int s = 0; s < 7; s++) begin
      new_cnt = new_cnt + 3'(new_miss[s]);
    end
  end

  // Miss counter: up by new misses, down by one per fill
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      miss_cnt_r <= page_xlate_pkg::MISS_CNT_RESET;
    end else begin
      miss_cnt_r <= miss_cnt_r + new_cnt - 3'(fill);
    end
  end

  assign miss_count = miss_cnt_r;

  always_comb begin
    found = 1'b0;
    cur_src = '0;
    for (int s = 6; s >= 0; s--) begin
      if (pend_r[s]) begin
        found = 1'b1;
        cur_src = 3'(s);
      end
    end
  end

  assign fetch_vpn = req_vaddr[sel_r][31:OB];
  assign fill = (phase_r == page_xlate_pkg::PH_FILL) && mem_rsp_valid;
  assign mem_rd_valid = (phase_r == page_xlate_pkg::PH_FETCH);
  assign mem_rd_addr = table_base + {fetch_vpn, 2'b00};
  assign miss_phase = (phase_r != page_xlate_pkg::PH_NORMAL);

  always_comb begin
    load_vec = '0;
    if (fill) begin
      load_vec[victim_r] = 1'b1;
    end
  end

  // Miss phase: fetch one entry per pending source, then release it by hit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase_r <= page_xlate_pkg::PH_NORMAL;
      sel_r <= '0;
      victim_r <= '0;
    end else begin
      unique case (phase_r)
        page_xlate_pkg::PH_NORMAL: begin
          if (found) begin
            sel_r <= cur_src;
            phase_r <= page_xlate_pkg::PH_FETCH;
          end
        end
        page_xlate_pkg::PH_FETCH: begin
          if (mem_rd_ready) begin
            phase_r <= page_xlate_pkg::PH_FILL;
          end
        end
        page_xlate_pkg::PH_FILL: begin
          if (mem_rsp_valid) begin
            victim_r <= IW'(victim_r + 1'b1);
            phase_r <= page_xlate_pkg::PH_NORMAL;
          end
        end
        default: begin
          phase_r <= page_xlate_pkg::PH_NORMAL;
        end
      endcase
    end
  end

  // Assertions
  property p_offset_kept;
    @(posedge core_clk) disable iff (!nrst)
      (req_valid[0] && req_ready[0]) |=> out_paddr[0][OB-1:0] == $past(req_vaddr[0][OB-1:0]);
  endproperty
  a_offset_kept: assert property (p_offset_kept) else $error("offset lost");

  property p_no_miss_release;
    @(posedge core_clk) disable iff (!nrst) pend_r[0] |-> !req_ready[0];
  endproperty
  a_no_miss_release: assert property (p_no_miss_release) else $error("miss released early");

  property p_release_after_fill;
    @(posedge core_clk) disable iff (!nrst) $fell(pend_r[0]) |-> $past(fill && sel_r == 3'h0);
  endproperty
  a_release_after_fill: assert property (p_release_after_fill) else $error("pending dropped without fill");

  property p_fetch_only_pending;
    @(posedge core_clk) disable iff (!nrst) mem_rd_valid |-> pend_r[sel_r];
  endproperty
  a_fetch_only_pending: assert property (p_fetch_only_pending) else $error("fetch without miss");

  property p_hit_forward;
    @(posedge core_clk) disable iff (!nrst)
      (req_valid[1] && hit[1] && !pend_r[1] && !out_valid[1]) |-> req_ready[1];
  endproperty
  a_hit_forward: assert property (p_hit_forward) else $error("hit stalled");

  property p_count_tracks;
    @(posedge core_clk) disable iff (!nrst) miss_cnt_r == pend_pop;
  endproperty
  a_count_tracks: assert property (p_count_tracks) else $error("counter wrong");

  property p_zero_idle;
    @(posedge core_clk) disable iff (!nrst)
      (pend_r == 7'h00) |-> miss_cnt_r == 3'h0 && phase_r == page_xlate_pkg::PH_NORMAL;
  endproperty
  a_zero_idle: assert property (p_zero_idle) else $error("counter not zero");

  sequence s_fill;
    phase_r == page_xlate_pkg::PH_FILL && mem_rsp_valid;
  endsequence
  property p_fill_clears;
    @(posedge core_clk) disable iff (!nrst) s_fill |=> !pend_r[$past(sel_r)];
  endproperty
  a_fill_clears: assert property (p_fill_clears) else $error("fill kept pending");

  property p_all_miss;
    @(posedge core_clk) disable iff (!nrst)
      (new_miss == 7'h7f && pend_r == 7'h00) |=> miss_count == 3'h7;
  endproperty
  a_all_miss: assert property (p_all_miss) else $error("seven misses not held");
endmodule

// ### tb/page_table_mem.sv
// Page-table memory model answering the unit's table fetches
`timescale 1ns/1ps
module page_table_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Read port
  input wire logic rd_valid,
  input wire logic [31:0] rd_addr,
  output logic rd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  // Control and status
  input wire logic [7:0] delay,
  output logic [31:0] reads
);
  logic busy;
  logic [7:0] cnt;
  logic [31:0] addr_r;
  always_ff @(posedge core_clk) begin
    rd_ready <= 1'b0;
    rsp_valid <= 1'b0;
    rsp_data <= ~rsp_data;
    if (!nrst) begin
      busy <= 1'b0;
      cnt <= 8'h0;
      reads <= 32'h0;
      rsp_data <= 32'h0;
    end else if (!busy) begin
      if (rd_valid && !rd_ready) begin
        if (cnt >= delay) begin
          rd_ready <= 1'b1;
          addr_r <= rd_addr;
          busy <= 1'b1;
          cnt <= 8'h0;
          reads <= reads + 32'h1;
        end else begin
          cnt <= cnt + 8'h1;
        end
      end
    end else if (cnt >= delay) begin
      // Low bits carry junk the unit must ignore
      rsp_valid <= 1'b1;
      rsp_data <= {addr_r[21:2] ^ 20'ha5c3e, addr_r[13:2]};
      busy <= 1'b0;
      cnt <= 8'h0;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
endmodule

// ### tb/tb_gpu_page_translation_unit.sv
// Self-checking bench for the page translation unit
`timescale 1ns/1ps
module tb_gpu_page_translation_unit;
  logic core_clk, nrst, invalidate, mem_rd_valid, mem_rd_ready, mem_rsp_valid, miss_phase;
  logic [6:0] req_valid, req_ready, out_valid, out_ready;
  logic [6:0][31:0] req_vaddr, out_paddr;
  logic [31:0] table_base, mem_rd_addr, mem_rsp_data, reads, rd0, seed;
  logic [2:0] miss_count, max_cnt;
  logic [7:0] mem_delay;
  int err_count, compares, cyc[7];
  gpu_page_translation_unit dut (.core_clk, .nrst, .req_valid, .req_vaddr, .req_ready, .out_valid,
    .out_paddr, .out_ready, .table_base, .invalidate, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready,
    .mem_rsp_valid, .mem_rsp_data, .miss_count, .miss_phase);
  page_table_mem mem (.core_clk, .nrst, .rd_valid(mem_rd_valid), .rd_addr(mem_rd_addr),
    .rd_ready(mem_rd_ready), .rsp_valid(mem_rsp_valid), .rsp_data(mem_rsp_data), .delay(mem_delay), .reads);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] exp_pa(logic [31:0] va);
    logic [31:0] e;
    e = table_base + {va[31:12], 2'b00};
    return {e[21:2] ^ 20'ha5c3e, va[11:0]};
  endfunction
  task check(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict();
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Issue one request per masked source and collect every translated access
  task run(logic [6:0] mask, logic [31:0] va[7], bit stall);
    logic [6:0] taken, left;
    @(negedge core_clk);
    left = mask;
    max_cnt = 3'h0;
    req_valid = mask;
    for (int i = 0; i < 7; i++) req_vaddr[i] = va[i];
    for (int n = 0; n < 600 && left != 7'h0; n++) begin
      #1;
      taken = req_valid & req_ready;
      @(negedge core_clk);
      req_valid &= ~taken;
      if (miss_count > max_cnt) max_cnt = miss_count;
      out_ready = stall ? 7'(rnd()) : 7'h7f;
      for (int i = 0; i < 7; i++) begin
        if (out_valid[i] && out_ready[i] && left[i]) begin
          check(out_paddr[i], exp_pa(va[i]));
          left[i] = 1'b0;
          cyc[i] = n;
        end
      end
    end
    check(left, 0);
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
  initial begin
    logic [31:0] va[7], t;
    seed = 32'h180f;
    nrst = 0;
    req_valid = 0;
    req_vaddr = '0;
    out_ready = '1;
    invalidate = 0;
    mem_delay = 2;
    table_base = rnd() & 32'hffff_fffc;
    repeat (10) @(negedge core_clk);
    nrst = 1;
    for (int i = 0; i < 7; i++) begin
      t = rnd();
      va[i] = {t[31:15], 3'(i), t[11:0]};
    end
    rd0 = reads;
    run(7'h7f, va, 1);
    check(max_cnt, 7);
    check(reads - rd0, 7);
    check({miss_phase, miss_count}, 0);
    for (int i = 0; i < 7; i++) va[i][11:0] = 12'(rnd());
    rd0 = reads;
    run(7'h7f, va, 1);
    check(reads - rd0, 0);
    mem_delay = 30;
    va[1] ^= 32'h8000_0000;
    run(7'h03, va, 0);
    check(cyc[0], 0);
    for (int r = 0; r < 8; r++) begin
      mem_delay = 8'(rnd() & 32'h3);
      for (int i = 0; i < 7; i++) begin
        t = rnd();
        va[i] = {t[31:15], 3'(i), t[11:0]};
      end
      run(7'(rnd()) | 7'h01, va, 1);
      check({miss_phase, miss_count}, 0);
    end
    // Requesters are idle and drained before the flush
    invalidate = 1;
    table_base = rnd() & 32'hffff_fffc;
    @(negedge core_clk);
    invalidate = 0;
    rd0 = reads;
    run(7'h7f, va, 1);
    check(reads - rd0, 7);
    print_verdict();
  end
endmodule
